// ### dsp_defines.svh
// Purpose : Offsets, field positions, reset values and widths of the slice
// Assumes : Included by bare name; definitions only
// Notes   : Register offsets are byte addresses on a 32-bit APB
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSP_OFS_CTRL      12'h000
`define DSP_OFS_TGT_LO    12'h004
`define DSP_OFS_TGT_HI    12'h008
`define DSP_OFS_MASK_LO   12'h00C
`define DSP_OFS_MASK_HI   12'h010
`define DSP_OFS_STATUS    12'h014

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define DSP_CTRL_SEL_TGT  0
`define DSP_CTRL_SEL_MASK 1
`define DSP_CTRL_RND_LO   2
`define DSP_CTRL_RND_HI   3
`define DSP_CTRL_CLR_EN   4
`define DSP_CTRL_CLR_POL  5
`define DSP_CTRL_DET_USED 6

// ----------------------------------------------------------------
// Reset values, widths and APB wait count
// ----------------------------------------------------------------
`define DSP_TGT_RESET     48'h0000_0000_0000
`define DSP_MASK_RESET    48'h3FFF_FFFF_FFFF
`define DSP_DW            48
`define DSP_PPW           43
`define DSP_APB_RDY_WAIT  1

`endif

// ### dsp_pkg.sv
// Purpose : Types shared by the slice files
// Assumes : Nothing beyond the tool
// Notes   : Widths follow the defines header
`default_nettype none
package dsp_pkg;

  // Rounding mask choice
  typedef enum logic [1:0] {
    RND_SEL_MASK,
    RND_MASK_ONE,
    RND_MASK_TWO,
    RND_RSVD
  } dsp_rnd_type;

  // Software detector configuration
  typedef struct packed {
    logic [47:0] target;
    logic [47:0] mask;
    logic        sel_target_c;
    logic        sel_mask_c;
    dsp_rnd_type rnd;
    logic        auto_clear_on_detect;
    logic        auto_clear_polarity;
    logic        detector_used;
  } dsp_cfg_type;

  // Everything the output stage holds
  typedef struct packed {
    logic [47:0] p;
    logic        ovf;
    logic        unf;
    logic        det;
    logic        det_b;
    logic        cout;
    logic        msign;
  } dsp_res_type;

endpackage
`default_nettype wire

// ### dsp_pipe_reg.sv
// Purpose : One optional pipeline stage with enable and stage reset
// Assumes : Reset inputs are synchronous to mclk_in
// Notes   : PRESENT=0 makes the stage a plain wire
`default_nettype none
module dsp_pipe_reg
#(
  parameter int WIDTH   = 1,
  parameter bit PRESENT = 1'b1
)
(
  // Clock and resets
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             rst_in,
  // Data
  input  wire logic             en_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] q_q;

  // ----------------------------------------------------------------
  // Stage storage
  // ----------------------------------------------------------------
  generate
    if (PRESENT)
    begin : g_reg
      // Stage reset wins over the enable
      always_ff @(posedge mclk_in)
      begin
        if (!rst_n_in || rst_in)
          q_q <= '0;
        else if (en_in)
          q_q <= d_in;
      end
      assign q_out = q_q;
    end
    else
    begin : g_wire
      // No storage: pass straight through
      assign q_q   = '0;
      assign q_out = d_in;
    end
  endgenerate

endmodule // dsp_pipe_reg
`default_nettype wire

// ### dsp_slice.sv
// Purpose : Pipeline stages and pattern detector of an arithmetic slice
// Assumes : All inputs come from logic on mclk_in
// Notes   : Detector settings are software registers on APB
//
// The APB register port and the register offsets are this design's own decisions.
`include "dsp_defines.svh"
`default_nettype none

// Behaviour
// - Static 48-bit target, reset zero
// - Mask bits excluded from the compare
// - Target comes from static value or C
// - Mask comes from static value or C
// - Rounding masks override mask source select
// - Auto clear on match or on mismatch
// - Auto clear resets result next cycle
// - Detector-used setting has no logic effect
// - A has zero to two stages
// - B has zero to two stages
// - C has one optional stage
// - Product stage holds two partial products
// - Partial products summed by the adder
// - Operand select stage on control enable/reset
// - Carry source stage shares control enable/reset
// - ALU function stage has own enable/reset
// - Carry-in stage on common carry reset
// - Rounding carry stage on common carry reset
// - Output stage holds result and flags
// - Output stage also drives cascade outputs
// - A and B counts 0, 1, 2
module dsp_slice
  import dsp_pkg::*;
#(
  parameter int A_STAGES     = 1,
  parameter int B_STAGES     = 1,
  parameter int C_STAGES     = 1,
  parameter int M_STAGES     = 1,
  parameter int P_STAGES     = 1,
  parameter int OPSEL_STAGES = 1,
  parameter int CSRC_STAGES  = 1,
  parameter int ALU_STAGES   = 1,
  parameter int CIN_STAGES   = 1,
  parameter int RCY_STAGES   = 1
)
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Data inputs
  input  wire logic [29:0] a_in,
  input  wire logic [17:0] b_in,
  input  wire logic [47:0] c_in,
  // Control inputs
  input  wire logic [6:0]  opsel_in,
  input  wire logic [3:0]  alu_function_in,
  input  wire logic [2:0]  carry_source_select_in,
  input  wire logic        carry_in_a_in,
  // Stage enables
  input  wire logic        a_stage1_en_in,
  input  wire logic        a_stage2_en_in,
  input  wire logic        b_stage1_en_in,
  input  wire logic        b_stage2_en_in,
  input  wire logic        c_en_in,
  input  wire logic        product_en_in,
  input  wire logic        control_en_in,
  input  wire logic        alu_func_en_in,
  input  wire logic        carry_in_en_in,
  input  wire logic        round_carry_en_in,
  input  wire logic        result_en_in,
  // Stage resets, active high, synchronous
  input  wire logic        a_rst_in,
  input  wire logic        b_rst_in,
  input  wire logic        c_rst_in,
  input  wire logic        product_rst_in,
  input  wire logic        control_rst_in,
  input  wire logic        alu_func_rst_in,
  input  wire logic        carry_rst_in,
  input  wire logic        result_rst_in,
  // Results
  output logic      [47:0] p_out,
  output logic             overflow_out,
  output logic             underflow_out,
  output logic             detect_flag_out,
  output logic             detect_flag_b_out,
  output logic             carry_out_b_out,
  // Cascade to next slice
  output logic      [47:0] result_cascade_out,
  output logic             carry_cascade_out,
  output logic             product_sign_cascade_out
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (A_STAGES > 2 || B_STAGES > 2 || A_STAGES < 0 || B_STAGES < 0)
    begin : g_bad_ab
      $error("A and B stage counts must be 0, 1 or 2");
    end
    if (C_STAGES > 1 || M_STAGES > 1 || P_STAGES > 1 ||
        OPSEL_STAGES > 1 || CSRC_STAGES > 1 || ALU_STAGES > 1 ||
        CIN_STAGES > 1 || RCY_STAGES > 1 ||
        (C_STAGES | M_STAGES | P_STAGES | OPSEL_STAGES | CSRC_STAGES |
         ALU_STAGES | CIN_STAGES | RCY_STAGES) < 0)
    begin : g_bad_one
      $error("Single-stage counts must be 0 or 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // A and B input stages
  // ----------------------------------------------------------------
  logic [29:0] a_pipe [0:2];
  logic [17:0] b_pipe [0:2];
  logic [1:0]  a_en;
  logic [1:0]  b_en;

  // A single stage is the second one, so only its enable counts
  assign a_en = {a_stage2_en_in, a_stage1_en_in};
  assign b_en = {b_stage2_en_in, b_stage1_en_in};
  assign a_pipe[0] = a_in;
  assign b_pipe[0] = b_in;

  // Stage 0 exists for count 2, stage 1 for counts 1 and 2
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ab
      dsp_pipe_reg #(
        .WIDTH   (30),
        .PRESENT (A_STAGES > 1 - gi)
      ) u_a (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .rst_in   (a_rst_in),
        .en_in    (a_en[gi]),
        .d_in     (a_pipe[gi]),
        .q_out    (a_pipe[gi+1])
      );
      dsp_pipe_reg #(
        .WIDTH   (18),
        .PRESENT (B_STAGES > 1 - gi)
      ) u_b (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .rst_in   (b_rst_in),
        .en_in    (b_en[gi]),
        .d_in     (b_pipe[gi]),
        .q_out    (b_pipe[gi+1])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // C and control stages
  // ----------------------------------------------------------------
  logic [47:0] c_w;
  logic [6:0]  opsel_w;
  logic [2:0]  csrc_w;
  logic [3:0]  alu_w;
  logic        cin_w;
  logic        rcy_w;
  logic        rcy_src;
  logic [29:0] a_w;
  logic [17:0] b_w;

  assign a_w = a_pipe[2];
  assign b_w = b_pipe[2];

  // Symmetric rounding carry: set for non-negative product
  assign rcy_src = ~(a_w[24] ^ b_w[17]);

  dsp_pipe_reg #(.WIDTH(48), .PRESENT(C_STAGES == 1)) u_c (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (c_rst_in),
    .en_in    (c_en_in),
    .d_in     (c_in),
    .q_out    (c_w)
  );
  dsp_pipe_reg #(.WIDTH(7), .PRESENT(OPSEL_STAGES == 1)) u_opsel (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (control_rst_in),
    .en_in    (control_en_in),
    .d_in     (opsel_in),
    .q_out    (opsel_w)
  );
  dsp_pipe_reg #(.WIDTH(3), .PRESENT(CSRC_STAGES == 1)) u_csrc (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (control_rst_in),
    .en_in    (control_en_in),
    .d_in     (carry_source_select_in),
    .q_out    (csrc_w)
  );
  dsp_pipe_reg #(.WIDTH(4), .PRESENT(ALU_STAGES == 1)) u_alu (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (alu_func_rst_in),
    .en_in    (alu_func_en_in),
    .d_in     (alu_function_in),
    .q_out    (alu_w)
  );
  dsp_pipe_reg #(.WIDTH(1), .PRESENT(CIN_STAGES == 1)) u_cin (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (carry_rst_in),
    .en_in    (carry_in_en_in),
    .d_in     (carry_in_a_in),
    .q_out    (cin_w)
  );
  dsp_pipe_reg #(.WIDTH(1), .PRESENT(RCY_STAGES == 1)) u_rcy (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (carry_rst_in),
    .en_in    (round_carry_en_in),
    .d_in     (rcy_src),
    .q_out    (rcy_w)
  );

  // ----------------------------------------------------------------
  // Product stage
  // ----------------------------------------------------------------
  logic signed [42:0] prod_w;
  logic        [85:0] pp_w;
  logic        [42:0] pp0_w;
  logic        [42:0] pp1_w;

  // Two partial products; the lower one carries the whole product
  assign prod_w = 43'(signed'(a_w[24:0]) * signed'(b_w));

  dsp_pipe_reg #(.WIDTH(86), .PRESENT(M_STAGES == 1)) u_m (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (product_rst_in),
    .en_in    (product_en_in),
    .d_in     ({43'h000_0000_0000, prod_w}),
    .q_out    (pp_w)
  );
  assign pp0_w = pp_w[42:0];
  assign pp1_w = pp_w[85:43];

  // ----------------------------------------------------------------
  // Operand multiplexers and adder
  // ----------------------------------------------------------------
  dsp_res_type res_q;
  dsp_res_type res_d;
  dsp_res_type res_w;
  logic [47:0] x_w;
  logic [47:0] y_w;
  logic [47:0] z_w;
  logic        cy_w;
  logic [49:0] sum_w;
  logic        sub_w;

  // Partial products enter X and Y, summed below
  assign x_w = (opsel_w[1:0] == 2'h1) ? {{5{pp0_w[42]}}, pp0_w} :
               (opsel_w[1:0] == 2'h2) ? res_w.p :
               (opsel_w[1:0] == 2'h3) ? {a_w, b_w} : 48'h0000_0000_0000;
  assign y_w = (opsel_w[3:2] == 2'h1) ? {{5{pp1_w[42]}}, pp1_w} :
               (opsel_w[3:2] == 2'h2) ? 48'hFFFF_FFFF_FFFF :
               (opsel_w[3:2] == 2'h3) ? c_w : 48'h0000_0000_0000;
  assign z_w = (opsel_w[6:4] == 3'h2) ? res_w.p :
               (opsel_w[6:4] == 3'h3) ? c_w : 48'h0000_0000_0000;

  // Carry source: fabric carry or rounding carry
  assign cy_w = (csrc_w == 3'h0) ? cin_w :
                (csrc_w == 3'h7) ? rcy_w : 1'b0;

  // Function 0011 subtracts, every other code adds
  assign sub_w = (alu_w == 4'h3);
  assign sum_w = sub_w ?
    50'({{2{z_w[47]}}, z_w} - {{2{x_w[47]}}, x_w}
        - {{2{y_w[47]}}, y_w} - 50'(cy_w)) :
    50'({{2{z_w[47]}}, z_w} + {{2{x_w[47]}}, x_w}
        + {{2{y_w[47]}}, y_w} + 50'(cy_w));

  // ----------------------------------------------------------------
  // Pattern detector
  // ----------------------------------------------------------------
  dsp_cfg_type cfg_q;
  logic [47:0] tgt_w;
  logic [47:0] msk_sel_w;
  logic [47:0] msk_w;
  logic        match_w;

  assign tgt_w = cfg_q.sel_target_c ? c_w : cfg_q.target;
  assign msk_sel_w = cfg_q.sel_mask_c ? c_w : cfg_q.mask;
  // Rounding masks take precedence over the mask source
  assign msk_w =
    (cfg_q.rnd == RND_MASK_ONE) ? {~c_w[46:0], 1'b0} :
    (cfg_q.rnd == RND_MASK_TWO) ? {~c_w[45:0], 2'b00} :
    msk_sel_w;
  // Masked bits always compare equal; detector_used does not enter the compare
  assign match_w = &((sum_w[47:0] ~^ tgt_w) | msk_w);

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic clear_w;
  logic res_rst_w;

  assign res_d.p     = sum_w[47:0];
  assign res_d.ovf   = (sum_w[48] == 1'b0) && sum_w[47];
  assign res_d.unf   = (sum_w[48] == 1'b1) && !sum_w[47];
  assign res_d.det   = match_w;
  assign res_d.det_b = &((sum_w[47:0] ~^ ~tgt_w) | msk_w);
  assign res_d.cout  = sum_w[48] ^ sub_w;
  assign res_d.msign = pp0_w[42];

  // Registered detect picks the condition, clear lands one edge later
  assign clear_w = cfg_q.auto_clear_on_detect &&
                   (res_q.det ^ cfg_q.auto_clear_polarity);
  assign res_rst_w = result_rst_in || clear_w;

  dsp_pipe_reg #(.WIDTH($bits(dsp_res_type)), .PRESENT(P_STAGES == 1)) u_p (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rst_in   (res_rst_w),
    .en_in    (result_en_in),
    .d_in     (res_d),
    .q_out    (res_w)
  );

  // Feedback copy for the auto clear condition
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || res_rst_w)
      res_q <= '0;
    else if (result_en_in)
      res_q <= res_d;
  end

  // One stage feeds both the local and the cascade outputs
  assign p_out                    = res_w.p;
  assign overflow_out             = res_w.ovf;
  assign underflow_out            = res_w.unf;
  assign detect_flag_out          = res_w.det;
  assign detect_flag_b_out        = res_w.det_b;
  assign carry_out_b_out          = res_w.cout;
  assign result_cascade_out       = res_w.p;
  assign carry_cascade_out        = res_w.cout;
  assign product_sign_cascade_out = res_w.msign;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic        rdy_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic        acc_w;
  logic        wr_w;
  logic        hit_w;
  logic [31:0] rd_mux_w;
  logic [31:0] ctrl_rd_w;

  // Writes are taken at the edge that also sees pready high, reads at the edge that raises it
  assign acc_w = psel_in && penable_in;
  assign wr_w  = acc_w && rdy_q && pwrite_in && hit_w;
  assign hit_w = (paddr_in == `DSP_OFS_CTRL) ||
                 (paddr_in == `DSP_OFS_TGT_LO) ||
                 (paddr_in == `DSP_OFS_TGT_HI) ||
                 (paddr_in == `DSP_OFS_MASK_LO) ||
                 (paddr_in == `DSP_OFS_MASK_HI) ||
                 (paddr_in == `DSP_OFS_STATUS);

  assign ctrl_rd_w = {25'h000_0000, cfg_q.detector_used,
                      cfg_q.auto_clear_polarity,
                      cfg_q.auto_clear_on_detect, cfg_q.rnd,
                      cfg_q.sel_mask_c, cfg_q.sel_target_c};
  assign rd_mux_w =
    (paddr_in == `DSP_OFS_CTRL)    ? ctrl_rd_w :
    (paddr_in == `DSP_OFS_TGT_LO)  ? cfg_q.target[31:0] :
    (paddr_in == `DSP_OFS_TGT_HI)  ? {16'h0000, cfg_q.target[47:32]} :
    (paddr_in == `DSP_OFS_MASK_LO) ? cfg_q.mask[31:0] :
    (paddr_in == `DSP_OFS_MASK_HI) ? {16'h0000, cfg_q.mask[47:32]} :
    (paddr_in == `DSP_OFS_STATUS)  ?
      {27'h000_0000, res_w.cout, res_w.unf, res_w.ovf,
       res_w.det_b, res_w.det} : 32'h0000_0000;

  // One wait state; ready drops after each completed access
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      rdy_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      rdy_q   <= acc_w && !rdy_q;
      rdata_q <= (acc_w && !rdy_q && !pwrite_in) ? rd_mux_w : 32'h0000_0000;
      err_q   <= acc_w && !rdy_q && !hit_w;
    end
  end

  // Configuration writes
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q        <= '0;
      cfg_q.target <= `DSP_TGT_RESET;
      cfg_q.mask   <= `DSP_MASK_RESET;
    end
    else if (wr_w)
    begin
      case (paddr_in)
        `DSP_OFS_CTRL:
        begin
          cfg_q.sel_target_c <= pwdata_in[`DSP_CTRL_SEL_TGT];
          cfg_q.sel_mask_c   <= pwdata_in[`DSP_CTRL_SEL_MASK];
          cfg_q.rnd <= dsp_rnd_type'(
            pwdata_in[`DSP_CTRL_RND_HI:`DSP_CTRL_RND_LO]);
          cfg_q.auto_clear_on_detect <= pwdata_in[`DSP_CTRL_CLR_EN];
          cfg_q.auto_clear_polarity  <= pwdata_in[`DSP_CTRL_CLR_POL];
          cfg_q.detector_used        <= pwdata_in[`DSP_CTRL_DET_USED];
        end
        `DSP_OFS_TGT_LO:  cfg_q.target[31:0]  <= pwdata_in;
        `DSP_OFS_TGT_HI:  cfg_q.target[47:32] <= pwdata_in[15:0];
        `DSP_OFS_MASK_LO: cfg_q.mask[31:0]    <= pwdata_in;
        `DSP_OFS_MASK_HI: cfg_q.mask[47:32]   <= pwdata_in[15:0];
        default:          cfg_q <= cfg_q;
      endcase
    end
  end

  assign pready_out  = rdy_q;
  assign prdata_out  = rdata_q;
  assign pslverr_out = err_q;

endmodule // dsp_slice
`default_nettype wire

// ### dsp_slice_monitor.sv
// Purpose: Port checks on the slice pipeline and its APB side
// Assumes: Default stage counts of one
// Notes  : Bound to every dsp_slice instance
`default_nettype none
module dsp_slice_monitor
(
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Result stage
  input wire logic        result_rst_in,
  input wire logic        result_en_in,
  input wire logic [47:0] p_out,
  input wire logic        detect_flag_out,
  input wire logic [47:0] result_cascade_out,
  input wire logic        carry_cascade_out,
  input wire logic        product_sign_cascade_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // One domain, so clock and disable are given once
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rdy; psel_in && penable_in && !pready_out |=> pready_out;
  endproperty
  property p_pulse; pready_out |=> !pready_out; endproperty
  property p_err; pslverr_out |-> pready_out; endproperty
  property p_idle; !pready_out |-> prdata_out == 32'h0000_0000; endproperty
  property p_cause; pready_out |-> $past(psel_in) && $past(penable_in);
  endproperty
  property p_clr; result_rst_in |=> p_out == 48'h0 && !detect_flag_out;
  endproperty
  property p_crst;
    result_rst_in |=> !carry_cascade_out && !product_sign_cascade_out;
  endproperty
  // A cascade change needs the enable, or is a clear to zero
  property p_casc;
    $changed(result_cascade_out) |-> result_cascade_out == p_out &&
      ($past(result_en_in) || p_out == 48'h0);
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  a_pulse: assert property (p_pulse) else $error("pready long");
  a_err: assert property (p_err) else $error("lone pslverr");
  a_idle: assert property (p_idle) else $error("prdata idle");
  a_cause: assert property (p_cause) else $error("stray pready");
  a_clr: assert property (p_clr) else $error("result kept");
  a_crst: assert property (p_crst) else $error("cascade kept");
  a_casc: assert property (p_casc) else $error("cascade moved");
  // Main scenarios
  c_err: cover property (pslverr_out);
  c_det: cover property (detect_flag_out);
  c_clr: cover property (result_rst_in ##1 p_out == 48'h0);
endmodule // dsp_slice_monitor
bind dsp_slice dsp_slice_monitor mon (.*);
`default_nettype wire

// ### dsp_fabric_model.sv
// Purpose: Fabric side that steers the two input stage enables
// Assumes: STAGES matches the slice's stage count for that path
// Notes  : One request enable fans out to the legal stage enables
`default_nettype none
module dsp_fabric_model
#(
  parameter int STAGES = 1
)
(
  // Request and stage enables
  input  wire logic en_in,
  output logic      en1_out,
  output logic      en2_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A single stage may only see the second enable
  assign en1_out = (STAGES == 2) && en_in;
  assign en2_out = (STAGES >= 1) && en_in;
endmodule // dsp_fabric_model
`default_nettype wire

// ### tb_dsp_slice.sv
// Purpose: Self-checking bench for the slice pipeline and detector
// Assumes: Default stage counts, one wait state on APB
// Notes  : Operands 3 and 5 give a product of 15
`default_nettype none
module tb_dsp_slice;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rv;
  logic pready_out, pslverr_out, se, en, srst;
  logic [29:0] a_in;
  logic [17:0] b_in;
  logic [47:0] c_in, p_out, result_cascade_out;
  logic [6:0] opsel_in;
  logic [3:0] alu_function_in;
  logic [2:0] carry_source_select_in;
  logic carry_in_a_in, a_stage1_en_in, a_stage2_en_in, b_stage1_en_in;
  logic b_stage2_en_in, c_en_in, product_en_in, control_en_in;
  logic alu_func_en_in, carry_in_en_in, round_carry_en_in, result_en_in;
  logic a_rst_in, b_rst_in, c_rst_in, product_rst_in, control_rst_in;
  logic alu_func_rst_in, carry_rst_in, result_rst_in;
  logic overflow_out, underflow_out, detect_flag_out, detect_flag_b_out;
  logic carry_out_b_out, carry_cascade_out, product_sign_cascade_out;
  int failures, tests_run, cyc;
  logic [7:0] cv [5] = '{8'h01, 8'h02, 8'h06, 8'h0A, 8'h42};
  logic dv [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] av [2] = '{8'h10, 8'h30};
  logic [7:0] tv [2] = '{8'h0F, 8'h00};
  // Shared enables and stage resets keep the stimulus small
  assign {c_en_in, product_en_in, control_en_in, alu_func_en_in} = {4{en}};
  assign {carry_in_en_in, round_carry_en_in} = {2{en}};
  assign {a_rst_in, b_rst_in, c_rst_in, product_rst_in} = {4{srst}};
  assign {control_rst_in, alu_func_rst_in, carry_rst_in} = {3{srst}};
  dsp_slice dut (.*);
  dsp_fabric_model #(.STAGES(1)) fa (.en_in(en), .en1_out(a_stage1_en_in),
    .en2_out(a_stage2_en_in));
  dsp_fabric_model #(.STAGES(1)) fb (.en_in(en), .en1_out(b_stage1_en_in),
    .en2_out(b_stage2_en_in));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Sampled at the rising edge; no limit of its own, a hang is ended by the bench timeout
    do
      @(posedge mclk_in);
    while (pready_out !== 1'b1);
    rv = prdata_out;
    se = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h0000_0000);
    chk(rv, ex);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  // Lets a register write reach the registered flags
  task automatic settle;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock and hang guard
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {mclk_in, rst_n_in, psel_in, penable_in, pwrite_in, srst} = '0;
    {paddr_in, pwdata_in, carry_in_a_in, result_rst_in} = '0;
    {alu_function_in, carry_source_select_in} = '0;
    {failures, tests_run, cyc} = '0;
    a_in = 30'h3;
    b_in = 18'h5;
    c_in = 48'h0F;
    opsel_in = 7'h05;
    en = 1'b1;
    result_en_in = 1'b1;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(12'h004, 32'h0000_0000);
    rd(12'h008, 32'h0000_0000);
    rd(12'h00C, 32'hFFFF_FFFF);
    rd(12'h010, 32'h0000_3FFF);
    rd(12'h020, 32'h0000_0000);
    chk(se, 1'b1);
    chk(p_out, 8'h0F);
    a_in <= 30'h7;
    repeat (2) @(posedge mclk_in);
    #1 chk(p_out, 8'h0F);
    @(posedge mclk_in);
    #1 chk(p_out, 8'h23);
    @(posedge mclk_in);
    result_en_in <= 1'b0;
    a_in <= 30'h3;
    repeat (4) @(posedge mclk_in);
    #1 chk(p_out, 8'h23);
    @(posedge mclk_in);
    result_rst_in <= 1'b1;
    @(posedge mclk_in);
    result_rst_in <= 1'b0;
    #1 chk(p_out, 8'h00);
    @(posedge mclk_in);
    srst <= 1'b1;
    en <= 1'b0;
    result_en_in <= 1'b1;
    @(posedge mclk_in);
    srst <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk(p_out, 8'h00);
    @(posedge mclk_in);
    en <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 chk(p_out, 8'h0F);
    wr(12'h00C, 32'h0000_0000);
    wr(12'h010, 32'h0000_0000);
    wr(12'h004, 32'h0000_000F);
    settle();
    chk(detect_flag_out, 1'b1);
    chk(p_out, 8'h0F);
    // Status word and the flags that ride with the result
    rd(12'h014, 32'h0000_0001);
    chk(result_cascade_out, 8'h0F);
    chk({overflow_out, underflow_out, detect_flag_b_out, carry_out_b_out,
         carry_cascade_out, product_sign_cascade_out}, 6'h00);
    wr(12'h004, 32'h0000_000E);
    settle();
    chk(detect_flag_out, 1'b0);
    wr(12'h00C, 32'h0000_0001);
    settle();
    chk(detect_flag_out, 1'b1);
    wr(12'h00C, 32'h0000_0000);
    // Source selects, both rounding masks and the no-effect bit
    for (int i = 0; i < 5; i++)
    begin
      wr(12'h000, {24'h0, cv[i]});
      settle();
      chk(detect_flag_out, dv[i]);
    end
    // Clear on match, then on mismatch
    for (int i = 0; i < 2; i++)
    begin
      wr(12'h004, {24'h0, tv[i]});
      wr(12'h000, {24'h0, av[i]});
      // A result that never settles is ended by the bench timeout
      while (p_out !== 48'h0000_0000_000F)
      begin
        @(posedge mclk_in);
        #1;
      end
      @(posedge mclk_in);
      #1 chk(p_out, 8'h00);
    end
    give_verdict();
  end
endmodule // tb_dsp_slice
`default_nettype wire
